// ===== mbcs_pkg.sv
package mbcs_pkg;

	// ****************************************
	// Operating modes and space sizes
	// ****************************************
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_MEMEXP = 2'b01,
		MODE_RSVD = 2'b10,
		MODE_MICRO = 2'b11
	} mbcs_mode_t;

	localparam logic [1:0] SIZE_1M = 2'b00;
	localparam logic [1:0] SIZE_4M = 2'b11;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		mbcs_mode_t proc_mode;
		logic space_size_hi_bit;
		logic space_size_lo_bit;
		logic internal_area_extend_bit;
		logic internal_rom_extend_bit;
		logic flash_variant;
	} mbcs_cfg_t;

	typedef struct packed {
		logic bank_offset_bit;
		logic [2:0] bank_select;
	} mbcs_bank_t;

	// ****************************************
	// Address map boundaries
	// ****************************************
	localparam int ADDR_W = 20;
	localparam logic [19:0] CS3_LO = 20'h04000;
	localparam logic [19:0] CS3_HI = 20'h07fff;
	localparam logic [19:0] CS2_LO = 20'h08000;
	localparam logic [19:0] CS2_LO_EXT = 20'h10000;
	localparam logic [19:0] CS2_HI = 20'h26fff;
	localparam logic [19:0] CS1_LO = 20'h28000;
	localparam logic [19:0] CS1_HI = 20'h2ffff;
	localparam logic [19:0] CS1_HI_4M = 20'h3ffff;
	localparam logic [19:0] CS0_LO = 20'h30000;
	localparam logic [19:0] CS0_LO_4M = 20'hc0000;
	localparam logic [19:0] CS0_HI_MEMEXP = 20'hcffff;
	localparam logic [19:0] CS0_HI_MEMEXP_EXT = 20'h7ffff;
	localparam logic [19:0] CS0_HI_MICRO = 20'hfffff;
	localparam logic [19:0] WIN_LO = 20'h40000;
	localparam logic [19:0] WIN_HI = 20'hbffff;
	localparam logic [19:0] BANK_OFFSET = 20'h40000;
	localparam logic [19:0] ROMX_LO = 20'h0f000;
	localparam logic [19:0] ROMX_HI = 20'h0ffff;

	// Reset values of the pins
	localparam logic [3:0] CS_IDLE = 4'hf;
	localparam logic [19:0] ADDR_RST = 20'h00000;

endpackage

// ===== mbcs_top.sv
`timescale 1ns/1ns
module mbcs_top (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic I_ACCESS,
	input wire logic [19:0] I_ADDR,
	input wire mbcs_pkg::mbcs_cfg_t I_CFG,
	input wire mbcs_pkg::mbcs_bank_t I_DATA_BANK_REG,
	output logic [19:0] O_ADDR,
	output logic O_CHIP_SELECT_FIRST_N,
	output logic O_CHIP_SELECT_SECOND_N,
	output logic O_CHIP_SELECT_THIRD_N,
	output logic O_CHIP_SELECT_FOURTH_N,
	output logic O_INTERNAL_ROM_HIT,
	output logic O_BANK_WINDOW,
	output logic O_SIZE_RESERVED
);

	// ****************************************
	// Helpers
	// ****************************************

	// Inclusive address range check
	function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// ****************************************
	// Mode decode
	// ****************************************
	logic [1:0] size_code;
	logic ext_mode;
	logic micro_mode;
	logic big_map;
	logic size_rsvd;
	logic area_ext;
	logic half_mode;

	// Single-chip and the illegal mode code keep the bus idle
	assign micro_mode = I_CFG.proc_mode == mbcs_pkg::MODE_MICRO;
	assign ext_mode = micro_mode || (I_CFG.proc_mode == mbcs_pkg::MODE_MEMEXP);
	assign size_code = {I_CFG.space_size_hi_bit, I_CFG.space_size_lo_bit};
	assign big_map = ext_mode && (size_code == mbcs_pkg::SIZE_4M);
	assign size_rsvd = (size_code != mbcs_pkg::SIZE_1M) && (size_code != mbcs_pkg::SIZE_4M);
	assign area_ext = I_CFG.internal_area_extend_bit;
	assign half_mode = area_ext && !micro_mode;

	// ****************************************
	// Area decode
	// ****************************************
	logic rom_ext_hit;
	logic [19:0] cs2_lo;
	logic [19:0] cs1_hi;
	logic [19:0] cs0_lo;
	logic [19:0] cs0_hi;
	logic hit_cs3;
	logic hit_cs2;
	logic hit_cs1;
	logic hit_cs0;
	logic hit_win;
	logic ext_acc;

	// Internal ROM extension hides its page from the bus
	assign rom_ext_hit = ext_mode && I_CFG.flash_variant && I_CFG.internal_rom_extend_bit
		&& in_range(I_ADDR, mbcs_pkg::ROMX_LO, mbcs_pkg::ROMX_HI);

	// Area limits by mode and map
	assign cs2_lo = I_CFG.internal_rom_extend_bit ? mbcs_pkg::CS2_LO_EXT : mbcs_pkg::CS2_LO;
	assign cs1_hi = big_map ? mbcs_pkg::CS1_HI_4M : mbcs_pkg::CS1_HI;
	assign cs0_lo = big_map ? mbcs_pkg::CS0_LO_4M : mbcs_pkg::CS0_LO;
	assign cs0_hi = micro_mode ? mbcs_pkg::CS0_HI_MICRO
		: (area_ext ? mbcs_pkg::CS0_HI_MEMEXP_EXT : mbcs_pkg::CS0_HI_MEMEXP);

	// One area per address, fourth area vanishes with the extension bit
	assign hit_cs3 = !area_ext && in_range(I_ADDR, mbcs_pkg::CS3_LO, mbcs_pkg::CS3_HI);
	assign hit_cs2 = !rom_ext_hit && in_range(I_ADDR, cs2_lo, mbcs_pkg::CS2_HI);
	assign hit_cs1 = in_range(I_ADDR, mbcs_pkg::CS1_LO, cs1_hi);
	assign hit_cs0 = !hit_win && in_range(I_ADDR, cs0_lo, cs0_hi);
	assign hit_win = big_map && in_range(I_ADDR, mbcs_pkg::WIN_LO, mbcs_pkg::WIN_HI);
	assign ext_acc = I_ACCESS && ext_mode && !rom_ext_hit;

	// ****************************************
	// Pin values
	// ****************************************
	logic [3:0] cs_area_n;
	logic [3:0] cs_win_n;
	logic [3:0] cs_next;
	logic [19:0] addr_off;
	logic [19:0] addr_half;
	logic [19:0] addr_win;
	logic [19:0] addr_next;

	// Area selects, active low
	assign cs_area_n = ~{hit_cs3, hit_cs2, hit_cs1, hit_cs0};
	// Window drives bank number as levels, first select low
	assign cs_win_n = {I_DATA_BANK_REG.bank_select, 1'b0};
	assign cs_next = !ext_acc ? mbcs_pkg::CS_IDLE : (hit_win ? cs_win_n : cs_area_n);

	// Offset shifts the window, or picks the half of a bank
	assign addr_off = I_ADDR
		+ (I_DATA_BANK_REG.bank_offset_bit ? mbcs_pkg::BANK_OFFSET : 20'h00000);
	assign addr_half = {I_DATA_BANK_REG.bank_offset_bit, I_ADDR[18:0]};
	assign addr_win = half_mode ? addr_half : addr_off;
	assign addr_next = hit_win ? addr_win : I_ADDR;

	// ****************************************
	// Output registers
	// ****************************************
	logic [3:0] cs_reg;
	logic [19:0] addr_reg;
	logic rom_reg;
	logic win_reg;
	logic rsvd_reg;

	// Address holds its last external value between accesses
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			cs_reg <= mbcs_pkg::CS_IDLE;
			addr_reg <= mbcs_pkg::ADDR_RST;
		end else if (I_CE) begin
			cs_reg <= cs_next;
			if (ext_acc) begin
				addr_reg <= addr_next;
			end
		end
	end

	// Status flags
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			rom_reg <= 1'b0;
			win_reg <= 1'b0;
			rsvd_reg <= 1'b0;
		end else if (I_CE) begin
			rom_reg <= I_ACCESS && rom_ext_hit;
			win_reg <= ext_acc && hit_win;
			rsvd_reg <= size_rsvd;
		end
	end

	// Pins straight from flip-flops
	assign O_ADDR = addr_reg;
	assign O_CHIP_SELECT_FIRST_N = cs_reg[0];
	assign O_CHIP_SELECT_SECOND_N = cs_reg[1];
	assign O_CHIP_SELECT_THIRD_N = cs_reg[2];
	assign O_CHIP_SELECT_FOURTH_N = cs_reg[3];
	assign O_INTERNAL_ROM_HIT = rom_reg;
	assign O_BANK_WINDOW = win_reg;
	assign O_SIZE_RESERVED = rsvd_reg;

	// ****************************************
	// Checks
	// ****************************************

	// Single-chip keeps every select high
	property p_single_idle;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && (I_CFG.proc_mode == mbcs_pkg::MODE_SINGLE) |=> (cs_reg == 4'hf);
	endproperty
	a_single_idle: assert property (p_single_idle) else $error("select active in single-chip mode");

	// No access means all selects high
	property p_idle_high;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && !I_ACCESS |=> (cs_reg == 4'hf);
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("select active without access");

	// At most one area select low outside the window
	property p_one_area;
		@(posedge I_REF_CLK) disable iff (I_RST)
		!win_reg |-> $countones(~cs_reg) <= 1;
	endproperty
	a_one_area: assert property (p_one_area) else $error("several area selects low");

	// Window access drives bank number and first select low
	property p_window_bank;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && I_ACCESS && big_map && (I_ADDR[19:18] == 2'b01 || I_ADDR[19:18] == 2'b10)
		|=> win_reg && !O_CHIP_SELECT_FIRST_N
		&& (cs_reg[3:1] == $past(I_DATA_BANK_REG.bank_select));
	endproperty
	a_window_bank: assert property (p_window_bank) else $error("bank number not on selects");

	// Offset adds 40000h inside the window
	property p_offset_add;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && ext_acc && hit_win && !half_mode && I_DATA_BANK_REG.bank_offset_bit
		|=> (O_ADDR == 20'($past(I_ADDR) + 20'h40000));
	endproperty
	a_offset_add: assert property (p_offset_add) else $error("bank offset not applied");

	// Half select puts offset bit on the top address line
	property p_half_sel;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && ext_acc && hit_win && half_mode
		|=> (O_ADDR[19] == $past(I_DATA_BANK_REG.bank_offset_bit)) && (O_ADDR[18:0] == $past(I_ADDR[18:0]));
	endproperty
	a_half_sel: assert property (p_half_sel) else $error("half selection wrong");

	// Second area reaches 3FFFFh only in the 4-Mbyte map
	property p_cs1_end;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && ext_acc && (I_ADDR == 20'h3ffff) |=> (O_CHIP_SELECT_SECOND_N == !$past(big_map));
	endproperty
	a_cs1_end: assert property (p_cs1_end) else $error("second area end wrong");

	// Microprocessor mode first area reaches FFFFFh
	property p_micro_top;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && I_ACCESS && micro_mode && (I_ADDR == 20'hfffff) |=> !O_CHIP_SELECT_FIRST_N;
	endproperty
	a_micro_top: assert property (p_micro_top) else $error("top of map not in first area");

	// ROM extension page never selects external memory
	property p_rom_ext;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && I_ACCESS && rom_ext_hit |=> O_INTERNAL_ROM_HIT && (cs_reg == 4'hf);
	endproperty
	a_rom_ext: assert property (p_rom_ext) else $error("internal ROM page reached bus");

	// Reserved size codes flagged and decoded as the small map
	property p_size_rsvd;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && (size_code == 2'b01 || size_code == 2'b10) |=> O_SIZE_RESERVED && !O_BANK_WINDOW;
	endproperty
	a_size_rsvd: assert property (p_size_rsvd) else $error("reserved size not flagged");

	// Clock enable low freezes the pins
	property p_ce_hold;
		@(posedge I_REF_CLK) disable iff (I_RST)
		!I_CE |=> $stable(cs_reg) && $stable(addr_reg);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");

	// Fourth area while it exists
	property p_fourth_area;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && ext_acc && !area_ext && (I_ADDR[19:14] == 6'h01) |=> (cs_reg == 4'h7);
	endproperty
	a_fourth_area: assert property (p_fourth_area) else $error("fourth area select wrong");

	// Third area above the ROM page
	property p_third_area;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && ext_acc && (I_ADDR >= 20'h10000) && (I_ADDR <= 20'h26fff) |=> (cs_reg == 4'hb);
	endproperty
	a_third_area: assert property (p_third_area) else $error("third area select wrong");

	// Window address passes unchanged without offset
	property p_plain_window;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && ext_acc && hit_win && !half_mode && !I_DATA_BANK_REG.bank_offset_bit |=> (O_ADDR == $past(I_ADDR));
	endproperty
	a_plain_window: assert property (p_plain_window) else $error("window address moved");

	// Small map never opens the bank window
	property p_small_map;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && (size_code == 2'h0) |=> !O_BANK_WINDOW;
	endproperty
	a_small_map: assert property (p_small_map) else $error("bank window in small map");

	// ROM page only on flash parts
	property p_no_flash;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && !I_CFG.flash_variant |=> !O_INTERNAL_ROM_HIT;
	endproperty
	a_no_flash: assert property (p_no_flash) else $error("ROM page hit without flash");

	// Address lines hold outside expansion modes
	property p_single_addr;
		@(posedge I_REF_CLK) disable iff (I_RST)
		I_CE && !ext_mode |=> $stable(O_ADDR);
	endproperty
	a_single_addr: assert property (p_single_addr) else $error("address moved in single-chip mode");

	// Reset leaves the bus idle
	property p_reset_idle;
		@(posedge I_REF_CLK)
		I_RST |=> (cs_reg == 4'hf) && (addr_reg == 20'h00000) && !win_reg;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");

endmodule

// ===== mbcs_mem_model.sv
`timescale 1ns/1ns
// ****************************************
// External 4-Mbyte memory on the selects
// ****************************************
module mbcs_mem_model (
	input wire logic i_first_n,
	input wire logic i_second_n,
	input wire logic i_third_n,
	input wire logic i_fourth_n,
	input wire logic [19:0] i_addr,
	output logic o_sel,
	output logic [21:0] o_mem_addr
);
	// Memory address from selects and top line
	logic [21:0] live_addr;
	assign live_addr = {i_fourth_n, i_third_n, i_second_n, i_addr[19], i_addr[17:0]};
	// Enabled by an active-low first select
	assign o_sel = ~i_first_n;
	// Deselected lines show no stale value
	assign o_mem_addr = o_sel ? live_addr : ~live_addr;
endmodule

// ===== mbcs_top_bench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module mbcs_top_bench;
	logic I_REF_CLK = 1'b0;
	logic I_RST = 1'b1;
	logic I_CE = 1'b1;
	logic I_ACCESS = 1'b0;
	logic [19:0] I_ADDR = 20'h00000;
	mbcs_pkg::mbcs_cfg_t I_CFG = '0;
	mbcs_pkg::mbcs_bank_t I_DATA_BANK_REG = '0;
	logic [19:0] O_ADDR;
	logic cs0_n, cs1_n, cs2_n, cs3_n, rom_hit, win, rsv, mem_sel;
	logic [21:0] mem_addr;
	int err_total = 0;
	int checks_done = 0;
	// ****************************************
	// Clock, design and memory
	// ****************************************
	always #20 I_REF_CLK = ~I_REF_CLK;
	mbcs_top u_dut (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_ACCESS(I_ACCESS),
		.I_ADDR(I_ADDR), .I_CFG(I_CFG), .I_DATA_BANK_REG(I_DATA_BANK_REG), .O_ADDR(O_ADDR),
		.O_CHIP_SELECT_FIRST_N(cs0_n), .O_CHIP_SELECT_SECOND_N(cs1_n), .O_CHIP_SELECT_THIRD_N(cs2_n),
		.O_CHIP_SELECT_FOURTH_N(cs3_n), .O_INTERNAL_ROM_HIT(rom_hit), .O_BANK_WINDOW(win),
		.O_SIZE_RESERVED(rsv));
	mbcs_mem_model u_mem (.i_first_n(cs0_n), .i_second_n(cs1_n), .i_third_n(cs2_n),
		.i_fourth_n(cs3_n), .i_addr(O_ADDR), .o_sel(mem_sel), .o_mem_addr(mem_addr));
	// ****************************************
	// Tasks
	// ****************************************
	// Verdict and end of run
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One access cycle, then outputs one cycle later
	task t(input logic [1:0] md, input logic [1:0] sz, input logic [2:0] ext, input logic [3:0] bk,
		input logic [19:0] a, input logic [3:0] ecs, input logic [19:0] ea, input logic [2:0] efl);
		@(negedge I_REF_CLK);
		I_CFG = mbcs_pkg::mbcs_cfg_t'({md, sz, ext});
		I_DATA_BANK_REG = mbcs_pkg::mbcs_bank_t'(bk);
		I_ADDR = a;
		I_ACCESS = 1'b1;
		@(negedge I_REF_CLK);
		I_ACCESS = 1'b0;
		`CHK({cs3_n, cs2_n, cs1_n, cs0_n}, ecs)
		`CHK(O_ADDR, ea)
		`CHK({rom_hit, win, rsv}, efl)
	endtask
	// Cut a hang short
	initial begin
		#1000000;
		err_total++;
		test_done;
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (10) @(negedge I_REF_CLK);
		`CHK({cs3_n, cs2_n, cs1_n, cs0_n, O_ADDR, rom_hit, win, rsv}, 27'h7800000)
		I_RST = 1'b0;
		$display("test reset done");
		t(2'b01, 2'b00, 3'b000, 4'h0, 20'h04000, 4'b0111, 20'h04000, 3'b000);
		t(2'b01, 2'b00, 3'b000, 4'h0, 20'h08000, 4'b1011, 20'h08000, 3'b000);
		t(2'b01, 2'b00, 3'b000, 4'h0, 20'h2ffff, 4'b1101, 20'h2ffff, 3'b000);
		t(2'b01, 2'b00, 3'b000, 4'h0, 20'h30000, 4'b1110, 20'h30000, 3'b000);
		t(2'b01, 2'b00, 3'b000, 4'h0, 20'hcffff, 4'b1110, 20'hcffff, 3'b000);
		t(2'b11, 2'b00, 3'b000, 4'h0, 20'hfffff, 4'b1110, 20'hfffff, 3'b000);
		t(2'b00, 2'b00, 3'b000, 4'h0, 20'h28000, 4'b1111, 20'hfffff, 3'b000);
		t(2'b01, 2'b01, 3'b000, 4'h0, 20'h28000, 4'b1101, 20'h28000, 3'b001);
		t(2'b10, 2'b00, 3'b000, 4'h0, 20'h08000, 4'b1111, 20'h28000, 3'b000);
		$display("test one megabyte map done");
		t(2'b01, 2'b00, 3'b011, 4'h0, 20'h0f800, 4'b1111, 20'h28000, 3'b100);
		t(2'b01, 2'b00, 3'b011, 4'h0, 20'h10000, 4'b1011, 20'h10000, 3'b000);
		I_CE = 1'b0;
		t(2'b01, 2'b00, 3'b000, 4'h0, 20'h28000, 4'b1011, 20'h10000, 3'b000);
		I_CE = 1'b1;
		t(2'b01, 2'b00, 3'b010, 4'h0, 20'h0f800, 4'b1111, 20'h0f800, 3'b000);
		t(2'b01, 2'b00, 3'b100, 4'h0, 20'h04000, 4'b1111, 20'h04000, 3'b000);
		t(2'b01, 2'b00, 3'b100, 4'h0, 20'h7ffff, 4'b1110, 20'h7ffff, 3'b000);
		$display("test rom page and freeze done");
		t(2'b11, 2'b11, 3'b000, 4'h0, 20'h3ffff, 4'b1101, 20'h3ffff, 3'b000);
		t(2'b11, 2'b11, 3'b000, 4'h0, 20'hc0000, 4'b1110, 20'hc0000, 3'b000);
		t(2'b11, 2'b11, 3'b000, 4'h0, 20'h04000, 4'b0111, 20'h04000, 3'b000);
		t(2'b11, 2'b11, 3'b000, 4'hd, 20'h50000, 4'b1010, 20'h90000, 3'b010);
		t(2'b11, 2'b11, 3'b000, 4'h8, 20'hbffff, 4'b0000, 20'hfffff, 3'b010);
		for (int b = 0; b < 8; b++) begin
			t(2'b11, 2'b11, 3'b000, 4'(b), 20'h7ffff, {3'(b), 1'b0}, 20'h7ffff, 3'b010);
			`CHK(mem_addr, {3'(b), 19'h3ffff})
			`CHK(mem_sel, 1'b1)
		end
		$display("test four megabyte map done");
		t(2'b01, 2'b11, 3'b100, 4'hb, 20'h50000, 4'b0110, 20'hd0000, 3'b010);
		t(2'b01, 2'b11, 3'b100, 4'h3, 20'h50000, 4'b0110, 20'h50000, 3'b010);
		t(2'b01, 2'b11, 3'b000, 4'hb, 20'h50000, 4'b0110, 20'h90000, 3'b010);
		t(2'b11, 2'b11, 3'b100, 4'hb, 20'h50000, 4'b0110, 20'h90000, 3'b010);
		$display("test half bank done");
		I_RST = 1'b1;
		@(negedge I_REF_CLK);
		`CHK({cs3_n, cs2_n, cs1_n, cs0_n, O_ADDR, rom_hit, win, rsv}, 27'h7800000)
		I_RST = 1'b0;
		$display("test second reset done");
		test_done;
	end
endmodule
